// >>> logic/wkb_cfg.svh
// Register indices, field positions, reset values and bus codes of the wake bank.
// Behaviour
// - Status bit sets on event, holds until cleared
// - Status records events regardless of any enable
// - Writing one to status bit clears it
// - Writing zero to status bit changes nothing
// - Registers reset only by standby-supply power-on reset
// - Status four bits map pins 30..33,41,43,60,61
// - Status five bits map pins 50 through 57
// - Index nine is reserved, reads zero
// - Enable, status and master enable assert wake
// - Disabled source records status, never asserts wake
// - Enable one: bit0 reserved, bits1-7 named sources
// - Enable two bits map pins 10 through 17
// - Master enable bit0 at index two, default off
`ifndef WKB_CFG_SVH
`define WKB_CFG_SVH
// ------------------------------------------------------------
// Register indices; byte address is four times the index.
// ------------------------------------------------------------
`define WKB_IDX_MASTER 6'h02
`define WKB_IDX_STS4 6'h07
`define WKB_IDX_STS5 6'h08
`define WKB_IDX_RSVD 6'h09
`define WKB_IDX_EN1 6'h0a
`define WKB_IDX_EN2 6'h0b
`define WKB_IDX_IRQ_STS 6'h10
`define WKB_IDX_IRQ_MSK 6'h11
// ------------------------------------------------------------
// Fields, reset values and response codes.
// ------------------------------------------------------------
`define WKB_MASTER_BIT 0
`define WKB_EN1_WR_MASK 8'hfe
`define WKB_RST_BYTE 8'h00
`define WKB_RST_IRQ 3'h0
`define WKB_IRQ_WAKE_BIT 0
`define WKB_IRQ_STS4_BIT 1
`define WKB_IRQ_STS5_BIT 2
`define WKB_RESP_OKAY 2'h0
`define WKB_RESP_SLVERR 2'h2
`endif

// >>> logic/wkb_if.sv
// Interface between the bank controller and one sticky status bank.
`timescale 1ns/1ps
interface wkb_if #(parameter int W = 8);
  logic [W-1:0] evt;
  logic [W-1:0] clr;
  logic [W-1:0] sts;
  modport bank (input evt, input clr, output sts);
  modport ctl (output evt, output clr, input sts);
endinterface

// >>> logic/wkb_pkg.sv
// Types shared by the wake bank modules.
package wkb_pkg;
  typedef logic [7:0] wkb_byte_t;
  typedef enum logic {WKB_WR_IDLE, WKB_WR_RESP} wkb_wr_state_t;
  typedef enum logic {WKB_RD_IDLE, WKB_RD_RESP} wkb_rd_state_t;
endpackage

// >>> logic/wkb_status.sv
// Sticky write-one-to-clear status bank, one flip-flop per bit.
`timescale 1ns/1ps
module wkb_status (
  input wire logic clock,
  input wire logic rst_n,
  wkb_if.bank bus
);
  import wkb_pkg::*;
  localparam int W = $bits(bus.sts);
  logic [W-1:0] sts_reg;
  logic [W-1:0] sts_next;

  // ------------------------------------------------------------
  // Per-bit next value.
  // ------------------------------------------------------------
  // An event in the clearing cycle wins, so no wake is lost to a racing clear.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign sts_next[i] = bus.evt[i] | (sts_reg[i] & ~bus.clr[i]);
    end
  endgenerate

  // Only the standby power-on reset reaches these flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sts_reg <= '0;
    end else begin
      sts_reg <= sts_next;
    end
  end

  assign bus.sts = sts_reg;

  // ------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_event_sets_bit: assert property ((bus.evt != '0) |=> ((bus.sts & $past(bus.evt)) == $past(bus.evt)))
    else $error("Status bit did not set on its event.");
  chk_write0_keeps: assert property (1'b1 |=> ((bus.sts & $past(bus.sts & ~bus.clr)) == $past(bus.sts & ~bus.clr)))
    else $error("Status bit lost without a clearing one.");
  chk_no_false_set: assert property (1'b1 |=> ((bus.sts & ~$past(bus.sts) & ~$past(bus.evt)) == '0))
    else $error("Status bit set without an event.");
endmodule

// >>> logic/wkb_top.sv
// Wake event status and enable bank with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "wkb_cfg.svh"
module wkb_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_wake_30,
  input wire logic pin_wake_31,
  input wire logic pin_wake_32,
  input wire logic pin_wake_33,
  input wire logic pin_wake_41,
  input wire logic pin_wake_43,
  input wire logic pin_wake_60,
  input wire logic pin_wake_61,
  input wire logic pin_wake_50,
  input wire logic pin_wake_51,
  input wire logic pin_wake_52,
  input wire logic pin_wake_53,
  input wire logic pin_wake_54,
  input wire logic pin_wake_55,
  input wire logic pin_wake_56,
  input wire logic pin_wake_57,
  input wire wkb_pkg::wkb_byte_t status_one_in,
  input wire wkb_pkg::wkb_byte_t status_two_in,
  input wire wkb_pkg::wkb_byte_t enable_four_in,
  input wire wkb_pkg::wkb_byte_t enable_five_in,
  output logic wake_out_n,
  output logic irq
);
  import wkb_pkg::*;

  // ------------------------------------------------------------
  // Declarations.
  // ------------------------------------------------------------
  wkb_wr_state_t wr_st_reg;
  wkb_wr_state_t wr_st_next;
  wkb_rd_state_t rd_st_reg;
  wkb_rd_state_t rd_st_next;
  logic aw_got_reg;
  logic aw_got_next;
  logic w_got_reg;
  logic w_got_next;
  logic [5:0] wr_idx_reg;
  logic [5:0] wr_idx_next;
  wkb_byte_t wdata_reg;
  wkb_byte_t wdata_next;
  logic wstrb_reg;
  logic wstrb_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic master_wake_enable_reg;
  logic master_wake_enable_next;
  wkb_byte_t wake_enable_one_reg;
  wkb_byte_t wake_enable_one_next;
  wkb_byte_t wake_enable_two_reg;
  wkb_byte_t wake_enable_two_next;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_mask_next;
  logic wake_out_n_reg;
  logic wake_out_n_next;
  logic irq_reg;
  logic irq_next;
  logic wr_fire;
  logic wr_lane;
  logic [5:0] rd_idx;
  wkb_byte_t pins_four;
  wkb_byte_t pins_five;
  wkb_byte_t pairs;
  logic wake_any;

  wkb_if #(.W(8)) sts4_if ();
  wkb_if #(.W(8)) sts5_if ();
  wkb_if #(.W(3)) irq_if ();

  // ------------------------------------------------------------
  // Wake sources and status banks.
  // ------------------------------------------------------------
  // Pin order inside each byte is fixed by the register layout.
  assign pins_four = {pin_wake_61, pin_wake_60, pin_wake_43, pin_wake_41,
                      pin_wake_33, pin_wake_32, pin_wake_31, pin_wake_30};
  assign pins_five = {pin_wake_57, pin_wake_56, pin_wake_55, pin_wake_54,
                      pin_wake_53, pin_wake_52, pin_wake_51, pin_wake_50};

  // A write strobe on the low lane turns the written ones into clear pulses.
  assign wr_fire = (wr_st_reg == WKB_WR_IDLE) && aw_got_reg && w_got_reg;
  assign wr_lane = wr_fire && wstrb_reg;
  assign sts4_if.evt = pins_four;
  assign sts4_if.clr = (wr_lane && wr_idx_reg == `WKB_IDX_STS4) ? wdata_reg : 8'h00;
  assign sts5_if.evt = pins_five;
  assign sts5_if.clr = (wr_lane && wr_idx_reg == `WKB_IDX_STS5) ? wdata_reg : 8'h00;

  // Interrupt events: a new wake assertion and any pin event per bank.
  assign irq_if.evt = {|pins_five, |pins_four, wake_any & wake_out_n_reg};
  assign irq_if.clr = (wr_lane && wr_idx_reg == `WKB_IDX_IRQ_STS) ? wdata_reg[2:0] : 3'h0;

  wkb_status u_sts4 (
    .clock(clock),
    .rst_n(rst_n),
    .bus(sts4_if.bank)
  );

  wkb_status u_sts5 (
    .clock(clock),
    .rst_n(rst_n),
    .bus(sts5_if.bank)
  );

  wkb_status u_irq_sts (
    .clock(clock),
    .rst_n(rst_n),
    .bus(irq_if.bank)
  );

  // ------------------------------------------------------------
  // Wake output and interrupt.
  // ------------------------------------------------------------
  // Statuses one and two live elsewhere; only their enables are held here.
  assign pairs = (sts4_if.sts & enable_four_in) | (sts5_if.sts & enable_five_in) |
                 (status_one_in & wake_enable_one_reg) |
                 (status_two_in & wake_enable_two_reg);
  assign wake_any = (|pairs) && master_wake_enable_reg;

  always_comb begin
    wake_out_n_next = ~wake_any;
    irq_next = |(irq_if.sts & irq_mask_reg);
  end

  // Output flops keep the pins free of decode glitches.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_out_n_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      wake_out_n_reg <= wake_out_n_next;
      irq_reg <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // Write channel and register updates.
  // ------------------------------------------------------------
  // Address and data are taken in either order; the write happens once both are held.
  always_comb begin
    wr_st_next = wr_st_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    wr_idx_next = wr_idx_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    master_wake_enable_next = master_wake_enable_reg;
    wake_enable_one_next = wake_enable_one_reg;
    wake_enable_two_next = wake_enable_two_reg;
    irq_mask_next = irq_mask_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      wr_idx_next = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata[7:0];
      wstrb_next = s_axi_wstrb[0];
    end
    case (wr_st_reg)
      WKB_WR_IDLE: begin
        if (wr_fire) begin
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          bvalid_next = 1'b1;
          bresp_next = `WKB_RESP_OKAY;
          case (wr_idx_reg)
            `WKB_IDX_MASTER: begin
              if (wstrb_reg) begin
                master_wake_enable_next = wdata_reg[`WKB_MASTER_BIT];
              end
            end
            `WKB_IDX_EN1: begin
              if (wstrb_reg) begin
                wake_enable_one_next = wdata_reg & `WKB_EN1_WR_MASK;
              end
            end
            `WKB_IDX_EN2: begin
              if (wstrb_reg) begin
                wake_enable_two_next = wdata_reg;
              end
            end
            `WKB_IDX_IRQ_MSK: begin
              if (wstrb_reg) begin
                irq_mask_next = wdata_reg[2:0];
              end
            end
            `WKB_IDX_STS4, `WKB_IDX_STS5, `WKB_IDX_IRQ_STS, `WKB_IDX_RSVD: begin
              bresp_next = `WKB_RESP_OKAY;
            end
            default: begin
              bresp_next = `WKB_RESP_SLVERR;
            end
          endcase
          wr_st_next = WKB_WR_RESP;
        end
      end
      WKB_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_next = 1'b0;
          wr_st_next = WKB_WR_IDLE;
        end
      end
      default: begin
        wr_st_next = WKB_WR_IDLE;
      end
    endcase
    awready_next = (wr_st_next == WKB_WR_IDLE) && !aw_got_next;
    wready_next = (wr_st_next == WKB_WR_IDLE) && !w_got_next;
  end

  // Standby power-on reset is the only reset of this bank.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_st_reg <= WKB_WR_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
      wdata_reg <= `WKB_RST_BYTE;
      wstrb_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `WKB_RESP_OKAY;
      master_wake_enable_reg <= 1'b0;
      wake_enable_one_reg <= `WKB_RST_BYTE;
      wake_enable_two_reg <= `WKB_RST_BYTE;
      irq_mask_reg <= `WKB_RST_IRQ;
    end else begin
      wr_st_reg <= wr_st_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      wr_idx_reg <= wr_idx_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      master_wake_enable_reg <= master_wake_enable_next;
      wake_enable_one_reg <= wake_enable_one_next;
      wake_enable_two_reg <= wake_enable_two_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ------------------------------------------------------------
  // Read channel.
  // ------------------------------------------------------------
  // Data are captured at the address handshake, so rdata stays stable under back-pressure.
  assign rd_idx = s_axi_araddr[7:2];

  always_comb begin
    rd_st_next = rd_st_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    arready_next = arready_reg;
    case (rd_st_reg)
      WKB_RD_IDLE: begin
        arready_next = 1'b1;
        if (s_axi_arvalid && arready_reg) begin
          rvalid_next = 1'b1;
          arready_next = 1'b0;
          rresp_next = `WKB_RESP_OKAY;
          rdata_next = 32'h0000_0000;
          rd_st_next = WKB_RD_RESP;
          case (rd_idx)
            `WKB_IDX_MASTER: rdata_next[`WKB_MASTER_BIT] = master_wake_enable_reg;
            `WKB_IDX_STS4: rdata_next[7:0] = sts4_if.sts;
            `WKB_IDX_STS5: rdata_next[7:0] = sts5_if.sts;
            `WKB_IDX_RSVD: rdata_next = 32'h0000_0000;
            `WKB_IDX_EN1: rdata_next[7:0] = wake_enable_one_reg;
            `WKB_IDX_EN2: rdata_next[7:0] = wake_enable_two_reg;
            `WKB_IDX_IRQ_STS: rdata_next[2:0] = irq_if.sts;
            `WKB_IDX_IRQ_MSK: rdata_next[2:0] = irq_mask_reg;
            default: rresp_next = `WKB_RESP_SLVERR;
          endcase
        end
      end
      WKB_RD_RESP: begin
        if (s_axi_rready) begin
          rvalid_next = 1'b0;
          arready_next = 1'b1;
          rd_st_next = WKB_RD_IDLE;
        end
      end
      default: begin
        rd_st_next = WKB_RD_IDLE;
      end
    endcase
  end

  // Read state registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_st_reg <= WKB_RD_IDLE;
      rvalid_reg <= 1'b0;
      rresp_reg <= `WKB_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      arready_reg <= 1'b0;
    end else begin
      rd_st_reg <= rd_st_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      arready_reg <= arready_next;
    end
  end

  // ------------------------------------------------------------
  // Port drive.
  // ------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign wake_out_n = wake_out_n_reg;
  assign irq = irq_reg;

  // ------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_wake_asserts: assert property (wake_any |=> !wake_out_n)
    else $error("Wake output not asserted for an enabled set source.");
  chk_master_gates: assert property (!master_wake_enable_reg |=> wake_out_n)
    else $error("Wake output asserted with master enable off.");
  chk_disabled_quiet: assert property ((pairs == 8'h00) |=> wake_out_n)
    else $error("Wake output asserted with no enabled source set.");
  chk_rsvd_zero: assert property ((s_axi_arvalid && arready_reg && rd_idx == `WKB_IDX_RSVD)
      |=> (rvalid_reg && rdata_reg == 32'h0000_0000 && rresp_reg == `WKB_RESP_OKAY))
    else $error("Reserved location did not read zero.");
  chk_en1_bit0: assert property (wr_lane && wr_idx_reg == `WKB_IDX_EN1
      |=> wake_enable_one_reg == ($past(wdata_reg) & `WKB_EN1_WR_MASK))
    else $error("Enable one write not stored with bit zero reserved.");
  chk_en2_write: assert property (wr_lane && wr_idx_reg == `WKB_IDX_EN2
      |=> wake_enable_two_reg == $past(wdata_reg))
    else $error("Enable two write not stored.");
  chk_sts4_w1c: assert property (wr_lane && wr_idx_reg == `WKB_IDX_STS4
      |=> ((sts4_if.sts & $past(wdata_reg) & ~$past(pins_four)) == 8'h00))
    else $error("Writing one did not clear a status four bit.");
  chk_sts5_event: assert property ((pins_five != 8'h00) && !master_wake_enable_reg
      |=> ((sts5_if.sts & $past(pins_five)) == $past(pins_five)))
    else $error("Status five missed an event while disabled.");
  chk_bresp_next: assert property (wr_fire |=> bvalid_reg && !s_axi_awready && !s_axi_wready)
    else $error("Write response not raised after the write.");
  chk_rdata_hold: assert property (rvalid_reg && !s_axi_rready |=> rvalid_reg && $stable(rdata_reg))
    else $error("Read answer changed before it was taken.");

  cov_write_done: cover property (wr_fire ##1 bvalid_reg && s_axi_bready);
  cov_wake_rise: cover property (wake_out_n ##1 !wake_out_n);
  cov_irq_rise: cover property (!irq ##1 irq);
  cov_sts_clear: cover property (sts4_if.sts != 8'h00 ##1 sts4_if.sts == 8'h00);
endmodule

// >>> tb/wkb_host_pm.sv
// Behavioural host power-management side that watches the wake output.
`timescale 1ns/1ps
module wkb_host_pm (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wake_out_n,
  output int wake_reqs
);
  logic last_n;
  // --------------------------------------------------
  // Wake request counter
  // --------------------------------------------------
  // Counts each new low level; a held low is one request, as the host sees it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_n <= 1'b1;
      wake_reqs <= 0;
    end else begin
      last_n <= wake_out_n;
      if (last_n && !wake_out_n) begin
        wake_reqs <= wake_reqs + 1;
      end
    end
  end
endmodule

// >>> tb/wkb_top_tb.sv
// Self-checking bench of the wake bank against a small reference model.
`timescale 1ns/1ps
`include "wkb_cfg.svh"
module wkb_top_tb;
  import wkb_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, wake_out_n, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pins = 16'h0;
  wkb_byte_t st1 = 8'h00;
  wkb_byte_t st2 = 8'h00;
  wkb_byte_t en4 = 8'h00;
  wkb_byte_t en5 = 8'h00;
  logic [7:0] m4 = 8'h00;
  logic [7:0] m5 = 8'h00;
  logic [7:0] r;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 32'h5449;
  int wake_reqs;

  wkb_top #(.ADDR_W(8)) u_dut (.clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_wake_30(pins[0]), .pin_wake_31(pins[1]), .pin_wake_32(pins[2]),
    .pin_wake_33(pins[3]), .pin_wake_41(pins[4]), .pin_wake_43(pins[5]),
    .pin_wake_60(pins[6]), .pin_wake_61(pins[7]), .pin_wake_50(pins[8]),
    .pin_wake_51(pins[9]), .pin_wake_52(pins[10]), .pin_wake_53(pins[11]),
    .pin_wake_54(pins[12]), .pin_wake_55(pins[13]), .pin_wake_56(pins[14]),
    .pin_wake_57(pins[15]), .status_one_in(st1), .status_two_in(st2),
    .enable_four_in(en4), .enable_five_in(en5), .wake_out_n(wake_out_n), .irq(irq));

  wkb_host_pm u_host (.clock(clock), .rst_n(rst_n), .wake_out_n(wake_out_n),
    .wake_reqs(wake_reqs));

  // --------------------------------------------------
  // Clock and watchdog
  // --------------------------------------------------
  // The run needs well under a thousand cycles; the limit of 20000 cycles leaves ample margin.
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  // --------------------------------------------------
  // Checking and bus tasks
  // --------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready is a flop, so it is read at the falling edge to avoid edge races.
  task automatic wr(input logic [5:0] ix, input logic [7:0] d, input logic [1:0] er);
    bit ad, wd, ta, tw;
    ad = 0;
    wd = 0;
    @(posedge clock);
    awaddr <= {ix, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'($random(seed)), d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clock);
      ta = !ad && awready;
      tw = !wd && wready;
      @(posedge clock);
      if (ta) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    do @(negedge clock); while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
    @(posedge clock);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] ix, input logic [7:0] e, input logic [1:0] er);
    @(posedge clock);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clock); while (arready !== 1'b1);
    @(posedge clock);
    arvalid <= 1'b0;
    do @(negedge clock); while (rvalid !== 1'b1);
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", er, rresp);
    @(posedge clock);
    rready <= 1'b0;
  endtask

  // One-cycle pulse on one pin, mirrored into the model.
  task automatic ev(input int i);
    @(posedge clock);
    pins <= 16'h1 << i;
    @(posedge clock);
    pins <= 16'h0;
    if (i < 8) m4[i] = 1'b1;
    else m5[i-8] = 1'b1;
  endtask

  task automatic wk(input logic e);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("wake_out_n", e, wake_out_n);
  endtask

  task automatic rv();
    for (int k = 0; k < 6; k++) begin
      rd(6'(k == 0 ? 2 : k + 6), 8'h00, `WKB_RESP_OKAY);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rv();
    wr(`WKB_IDX_EN1, 8'hff, `WKB_RESP_OKAY);
    rd(`WKB_IDX_EN1, 8'hfe, `WKB_RESP_OKAY);
    r = 8'($random(seed));
    wr(`WKB_IDX_EN2, r, `WKB_RESP_OKAY);
    rd(`WKB_IDX_EN2, r, `WKB_RESP_OKAY);
    // A write without the low lane strobe must leave the register alone.
    wstrb <= 4'he;
    wr(`WKB_IDX_EN2, ~r, `WKB_RESP_OKAY);
    wstrb <= 4'h1;
    rd(`WKB_IDX_EN2, r, `WKB_RESP_OKAY);
    wr(`WKB_IDX_RSVD, 8'hff, `WKB_RESP_OKAY);
    rd(`WKB_IDX_RSVD, 8'h00, `WKB_RESP_OKAY);
    wr(6'h3f, 8'hff, `WKB_RESP_SLVERR);
    rd(6'h3f, 8'h00, `WKB_RESP_SLVERR);
    @(negedge clock);
    chk("irq", 1'b0, irq);
    // Every pin with the master enable off must still latch its bit.
    for (int i = 0; i < 16; i++) begin
      ev(i);
      rd(`WKB_IDX_STS4, m4, `WKB_RESP_OKAY);
      rd(`WKB_IDX_STS5, m5, `WKB_RESP_OKAY);
      @(negedge clock);
      chk("wake_out_n", 1'b1, wake_out_n);
    end
    wr(`WKB_IDX_STS4, 8'h00, `WKB_RESP_OKAY);
    rd(`WKB_IDX_STS4, m4, `WKB_RESP_OKAY);
    r = 8'($random(seed));
    wr(`WKB_IDX_STS4, r, `WKB_RESP_OKAY);
    m4 = m4 & ~r;
    rd(`WKB_IDX_STS4, m4, `WKB_RESP_OKAY);
    wr(`WKB_IDX_STS5, ~r, `WKB_RESP_OKAY);
    m5 = m5 & r;
    rd(`WKB_IDX_STS5, m5, `WKB_RESP_OKAY);
    // Wake output against enable, status and master enable.
    wr(`WKB_IDX_STS4, 8'hff, `WKB_RESP_OKAY);
    wr(`WKB_IDX_MASTER, 8'h01, `WKB_RESP_OKAY);
    ev(0);
    wk(1'b1);
    @(posedge clock);
    en4 <= 8'h01;
    wk(1'b0);
    wr(`WKB_IDX_STS4, 8'h01, `WKB_RESP_OKAY);
    wk(1'b1);
    @(posedge clock);
    en4 <= 8'h00;
    st1 <= 8'h04;
    wr(`WKB_IDX_EN1, 8'h04, `WKB_RESP_OKAY);
    wk(1'b0);
    wr(`WKB_IDX_MASTER, 8'h00, `WKB_RESP_OKAY);
    wk(1'b1);
    chk("wake_reqs", 2, wake_reqs);
    @(posedge clock);
    st1 <= 8'h00;
    // Interrupt raised by a status four event, masked and cleared.
    wr(`WKB_IDX_IRQ_STS, 8'h07, `WKB_RESP_OKAY);
    wr(`WKB_IDX_IRQ_MSK, 8'h02, `WKB_RESP_OKAY);
    @(negedge clock);
    chk("irq", 1'b0, irq);
    ev(3);
    wk(1'b1);
    chk("irq", 1'b1, irq);
    wr(`WKB_IDX_IRQ_STS, 8'h02, `WKB_RESP_OKAY);
    wk(1'b1);
    chk("irq", 1'b0, irq);
    // A second standby reset in mid-run clears every register.
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rv();
    finish_test();
  end
endmodule
